// ### sim/sfcd_host.sv
// Host side model that frames command bytes toward the decoder
module sfcd_host (
	// Clock
	input  wire logic  clk,
	// Byte link
	output logic       cs_n,
	output logic       rx_valid,
	output logic [7:0] rx_byte
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		cs_n = 1'b1;
		rx_valid = 1'b0;
		rx_byte = 8'h00;
	end

	// =====
	// Frame
	// Bytes go back to back; the idle lane is inverted so a stale byte never looks valid
	task automatic frame(input logic [7:0] q[$]);
		@(posedge clk);
		cs_n <= 1'b0;
		foreach (q[i]) begin
			rx_valid <= 1'b1;
			rx_byte  <= q[i];
			@(posedge clk);
		end
		rx_valid <= 1'b0;
		rx_byte  <= ~q[q.size()-1];
		cs_n     <= 1'b1;
		@(posedge clk);
	endtask
endmodule

// ### sim/tb.sv
// Self-checking bench for the serial flash command decoder
module tb;
	timeunit 1ns;
	timeprecision 100ps;

	// =====
	// Signals
	logic                 clk = 1'b0;
	logic                 arst_n = 1'b0;
	logic                 page_256 = 1'b1;
	logic                 op_done = 1'b0;
	logic                 cs_n;
	logic                 rx_valid;
	logic [7:0]           rx_byte;
	logic                 cmd_valid;
	logic                 reject;
	logic                 data_valid;
	logic                 deep_pd;
	logic [8:0]           cmd_page;
	logic [8:0]           cmd_byte;
	sfcd_pkg::sfcd_cmd_t  cmd_code;
	sfcd_pkg::sfcd_busy_t busy;
	logic                 stream_on;
	logic                 launch;
	logic [7:0]           data_byte;
	sfcd_pkg::sfcd_cmd_t  launch_cmd;
	int                   nlch = 0;
	int                   nstr = 0;
	int                   err_count = 0;
	int                   checks_done = 0;
	int                   ncmd = 0;
	int                   nrej = 0;
	int                   ndat = 0;
	int                   cyc = 0;
	// Opcode, expected code, dummies (7 means no address)
	localparam logic [15:0] TBL [27] = '{16'hD20C, 16'h0310, 16'h0B19, 16'hE824, 16'hD128,
		16'hD431, 16'h8438, 16'h8340, 16'h8848, 16'h8250, 16'h8158, 16'h5060, 16'h7C68,
		16'h5378, 16'h6080, 16'h5888, 16'h32C8, 16'h35D0, 16'h77D8, 16'hB9E7, 16'hABEF,
		16'hD7F7, 16'h9FFF, 16'h5431, 16'h520C, 16'h6824, 16'h57F7};
	// Four bytes and expected code, zero meaning refused
	localparam logic [39:0] MTB [10] = '{40'h3D_2A7F_A913, 40'h3D_2A7F_9A14,
		40'h3D_2A7F_CF15, 40'h3D_2A7F_FC16, 40'h3D_2A7F_3017, 40'h9B_0000_0018,
		40'h7C_9480_9A0E, 40'h3D_2A7F_1100, 40'h9B_0001_0000, 40'h00_0000_0000};

	sfcd_host i_host (.clk(clk), .cs_n(cs_n), .rx_valid(rx_valid), .rx_byte(rx_byte));
	sfcd_core i_dut (.clk(clk), .arst_n(arst_n), .cs_n(cs_n), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .page_256(page_256), .op_done(op_done), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_byte(cmd_byte), .stream_on(stream_on),
		.reject(reject), .data_valid(data_valid), .data_byte(data_byte), .launch(launch),
		.launch_cmd(launch_cmd), .busy(busy), .deep_pd(deep_pd));

	always #2.5 clk = ~clk;

	task automatic results();
		if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// =====
	// Monitor and timeout
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cmd_valid) ncmd <= ncmd + 1;
		if (reject) nrej <= nrej + 1;
		if (data_valid) ndat <= ndat + 1;
		if (launch) nlch <= nlch + 1;
		if (stream_on) nstr <= nstr + 1;
		if (cyc == 5000) begin
			err_count++;
			results();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic run(input logic [7:0] q[$]);
		ncmd = 0;
		nrej = 0;
		ndat = 0;
		nlch = 0;
		nstr = 0;
		i_host.frame(q);
		repeat (4) @(posedge clk);
	endtask

	task automatic finish_op();
		op_done <= 1'b1;
		@(posedge clk);
		op_done <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// =====
	// Scenarios
	task automatic t_table();
		logic [15:0] e;
		logic [7:0]  q[$];
		foreach (TBL[i]) begin
			e = TBL[i];
			q = {e[15:8]};
			if (e[2:0] != 3'h7) begin
				q = {q, 8'h01, 8'h23, 8'h45};
				repeat (e[2:0]) q.push_back(8'h5A);
			end
			// One data byte keeps the frame open past the header
			q.push_back(8'hC3);
			run(q);
			chk(ncmd, 1);
			chk(cmd_code, e[7:3]);
			chk(ndat, 1);
			chk(data_byte, 8'hC3);
			chk(nstr, 1);
			chk(nlch, e[7:3] inside {[5'd8:5'd17], 5'd28, 5'd29});
			if (nlch != 0) chk(launch_cmd, e[7:3]);
			if (e[15:8] == 8'h03) chk({cmd_page, cmd_byte}, 18'h2_4645);
			finish_op();
		end
		foreach (MTB[i]) begin
			q = {MTB[i][39:32], MTB[i][31:24], MTB[i][23:16], MTB[i][15:8]};
			run(q);
			chk(nrej, MTB[i][7:0] == 8'h00);
			chk(nlch, MTB[i][7:0] != 8'h00);
			if (MTB[i][7:0] != 8'h00) chk(cmd_code, MTB[i][4:0]);
			finish_op();
		end
		page_256 <= 1'b0;
		q = {8'h03, 8'h01, 8'h23, 8'h45};
		run(q);
		chk({cmd_page, cmd_byte}, 18'h1_2345);
		page_256 <= 1'b1;
	endtask

	task automatic probes(input logic [31:0] ops, input int exp);
		logic [7:0] q[$];
		for (int k = 0; k < 4; k++) begin
			q = {ops[31-8*k -: 8]};
			run(q);
			chk(nrej, exp);
		end
	endtask

	// Host deliberately sends more than status while configuration is busy
	task automatic t_busy();
		logic [7:0] q[$];
		q = {8'h81, 8'h01, 8'h23, 8'h45};
		run(q);
		chk(busy, 2'b01);
		probes(32'hD484_D79F, 0);
		probes(32'hD253_81E8, 1);
		finish_op();
		q[0] = 8'h53;
		run(q);
		chk(busy, 2'b10);
		probes(32'hD79F_D79F, 0);
		probes(32'hD484_D250, 1);
		finish_op();
		q = {8'h3D, 8'h2A, 8'h7F, 8'hFC};
		run(q);
		chk(busy, 2'b11);
		probes(32'hD7D7_D7D7, 0);
		probes(32'h9FD4_8153, 1);
		finish_op();
		chk(busy, 2'b00);
		q = {8'hB9};
		run(q);
		chk(deep_pd, 1'b1);
		probes(32'hD79F_0381, 1);
		probes(32'hABAB_ABAB, 0);
		chk(deep_pd, 1'b0);
	endtask

	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		t_table();
		t_busy();
		results();
	end
endmodule

// ### src/sfcd_core.sv
// Serial flash command decoder: byte framing, header parsing and launch control
//
// Notes on behaviour
// R01 - No new command while a read runs
// R02 - Erase busy admits buffer, status, id commands
// R03 - Transfer or program busy admits status, id
// R04 - Host sends only status during config busy
// R05 - Config commands block all except status
// R06 - D2H page read, address, four dummies
// R07 - 03H array read, address, no dummies
// R08 - 0BH array read, address, one dummy
// R09 - E8H array read, address, four dummies
// R10 - D1H buffer read plain, D4H one dummy
// R11 - 83H buffer to page with erase
// R12 - 88H buffer to page without erase
// R13 - 82H load buffer then program page
// R14 - 53H transfer, 60H compare, 58H rewrite
// R15 - 3D 2A 7F then A9/9A protect
// R16 - Same prefix, CFH/FCH protection register
// R17 - Same prefix, 30H sector lockdown
// R18 - 9BH then three zeros programs security
// R19 - 32H, 35H, 77H register reads
// R20 - B9H power down, ABH resume
// R21 - D7H status, 9FH identification, bare
// R22 - Legacy 54H, 52H, 68H, 57H accepted
// R23 - 84H, 81H, 50H, 7CH; chip erase sequence
// R24 - Binary pages: seventeen-bit linear address
// R25 - Standard pages: nine page, nine byte bits
module sfcd_core #(
	parameter int PAGE_W = sfcd_pkg::PAGE_BITS
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                arst_n,
	// Framed byte stream from the serial shifter
	input  wire logic                cs_n,
	input  wire logic                rx_valid,
	input  wire logic [7:0]          rx_byte,
	// Configuration and array status
	input  wire logic                page_256,
	input  wire logic                op_done,
	// Decoded command
	output logic                     cmd_valid,
	output sfcd_pkg::sfcd_cmd_t      cmd_code,
	output logic [PAGE_W-1:0]        cmd_page,
	output logic [PAGE_W-1:0]        cmd_byte,
	output logic                     stream_on,
	output logic                     reject,
	// Data phase bytes
	output logic                     data_valid,
	output logic [7:0]               data_byte,
	// Launch of frame-terminated operations
	output logic                     launch,
	output sfcd_pkg::sfcd_cmd_t      launch_cmd,
	// Device state
	output sfcd_pkg::sfcd_busy_t     busy,
	output logic                     deep_pd
);
	// ==========================================================
	// Parameter check
	if (PAGE_W != sfcd_pkg::PAGE_BITS) begin : g_chk
		$error("PAGE_W must match the address layout");
	end

	typedef enum logic [2:0] {
		ST_OPC   = 3'b000,
		ST_ADDR  = 3'b001,
		ST_DUMMY = 3'b010,
		ST_DATA  = 3'b011,
		ST_SKIP  = 3'b100
	} sfcd_state_t;

	sfcd_dec_if dif ();

	sfcd_state_t         state;
	sfcd_state_t         next_state;
	sfcd_pkg::sfcd_cmd_t cmd;
	sfcd_pkg::sfcd_cmd_t next_cmd;
	sfcd_pkg::sfcd_cmd_t resolved;
	logic [2:0]          cnt;
	logic [2:0]          next_cnt;
	logic [2:0]          dummy;
	logic [2:0]          next_dummy;
	logic [23:0]         addr;
	logic [23:0]         next_addr;
	logic [23:0]         addr_shift;
	logic                hdr_ok;
	logic                take;
	logic                fire;
	logic                bad;
	logic                pass;
	logic                launchable;
	logic [PAGE_W-1:0]   page_sel;
	logic [PAGE_W-1:0]   byte_sel;
	logic [3:0]          nbytes;

	// ==========================================================
	// Submodules
	sfcd_opdec u_dec (
		.dif (dif)
	);

	sfcd_guard u_guard (
		.clk        (clk),
		.arst_n     (arst_n),
		.launch     (launch),
		.launch_cmd (launch_cmd),
		.op_done    (op_done),
		.dif        (dif),
		.busy       (busy),
		.pd         (deep_pd)
	);

	// ==========================================================
	// Sequence tails resolve only after the fourth byte
	function automatic sfcd_pkg::sfcd_cmd_t resolve(input sfcd_pkg::sfcd_cmd_t c,
		input logic [23:0] a);
		resolve = c;
		case (c)
			sfcd_pkg::CMD_ER_SEC: begin
				// A real sector address never has the top tail bits set
				if (a == sfcd_pkg::CHIP_TAIL) resolve = sfcd_pkg::CMD_ER_CHIP; // see R23
			end
			sfcd_pkg::CMD_SEC_PGM: begin
				if (a != sfcd_pkg::SEC_TAIL) resolve = sfcd_pkg::CMD_NONE; // see R18
			end
			sfcd_pkg::CMD_PFX: begin
				resolve = sfcd_pkg::CMD_NONE;
				if (a[23:8] == sfcd_pkg::PFX_TAIL) begin
					case (a[7:0])
						sfcd_pkg::SEL_EN:    resolve = sfcd_pkg::CMD_PROT_EN; // see R15
						sfcd_pkg::SEL_DIS:   resolve = sfcd_pkg::CMD_PROT_DIS; // see R15
						sfcd_pkg::SEL_PR_ER: resolve = sfcd_pkg::CMD_PREG_ER; // see R16
						sfcd_pkg::SEL_PR_PG: resolve = sfcd_pkg::CMD_PREG_PGM; // see R16
						sfcd_pkg::SEL_LOCK:  resolve = sfcd_pkg::CMD_LOCK; // see R17
						default:             resolve = sfcd_pkg::CMD_NONE;
					endcase
				end
			end
			default: resolve = c;
		endcase
	endfunction

	// ==========================================================
	// Decode and selection
	assign take       = rx_valid && !cs_n;
	assign dif.opcode = rx_byte;
	assign addr_shift = {addr[15:0], rx_byte};
	assign resolved   = resolve(cmd, addr_shift);
	// Reads and buffer/status traffic end with the frame and start nothing
	assign launchable = sfcd_pkg::sfcd_grp(cmd) inside {sfcd_pkg::GRP_B_ER, sfcd_pkg::GRP_B_XF,
		sfcd_pkg::GRP_D, sfcd_pkg::GRP_MISC, sfcd_pkg::GRP_PWR}; // see R13
	// Leading don't-care bits are simply dropped by the part-selects
	assign page_sel = page_256 ? next_addr[sfcd_pkg::A256_PG_LSB +: PAGE_W] : // see R24
		next_addr[sfcd_pkg::A264_PG_LSB +: PAGE_W]; // see R25
	assign byte_sel = page_256 ? {1'b0, next_addr[sfcd_pkg::A256_PG_LSB-1:0]} : // see R24
		next_addr[sfcd_pkg::A264_PG_LSB-1:0]; // see R25

	// ==========================================================
	// Header state machine
	always_comb begin
		next_state = state;
		next_cmd   = cmd;
		next_cnt   = cnt;
		next_dummy = dummy;
		next_addr  = addr;
		fire       = 1'b0;
		bad        = 1'b0;
		pass       = 1'b0;
		if (take) begin
			case (state)
				ST_OPC: begin
					if (!dif.allowed || dif.cmd == sfcd_pkg::CMD_NONE) begin // see R02 see R03
						next_state = ST_SKIP;
						bad        = 1'b1;
					end else begin
						next_cmd   = dif.cmd;
						next_dummy = dif.n_dummy;
						next_addr  = 24'h00_0000;
						if (dif.has_addr) begin
							next_state = ST_ADDR;
							next_cnt   = sfcd_pkg::ADDR_LAST;
						end else begin
							next_state = ST_DATA; // see R21
							fire       = 1'b1;
						end
					end
				end
				ST_ADDR: begin
					next_addr = addr_shift;
					if (cnt != 3'h0) begin
						next_cnt = cnt - 3'h1;
					end else if (resolved == sfcd_pkg::CMD_NONE) begin
						next_state = ST_SKIP;
						bad        = 1'b1;
					end else if (dummy != 3'h0) begin
						next_cmd   = resolved;
						next_state = ST_DUMMY;
						next_cnt   = dummy - 3'h1;
					end else begin
						next_cmd   = resolved;
						next_state = ST_DATA; // see R07
						fire       = 1'b1;
					end
				end
				ST_DUMMY: begin
					if (cnt != 3'h0) begin
						next_cnt = cnt - 3'h1;
					end else begin
						next_state = ST_DATA; // see R06 see R08 see R09 see R10
						fire       = 1'b1;
					end
				end
				ST_DATA: pass = 1'b1;
				default: next_state = ST_SKIP;
			endcase
		end
	end

	// A read or any other command ends only when the frame closes
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_OPC;
			cmd   <= sfcd_pkg::CMD_NONE;
			cnt   <= 3'h0;
			dummy <= 3'h0;
			addr  <= 24'h00_0000;
		end else begin
			state <= cs_n ? ST_OPC : next_state; // see R01
			cmd   <= next_cmd;
			cnt   <= next_cnt;
			dummy <= next_dummy;
			addr  <= next_addr;
		end
	end

	// ==========================================================
	// Outputs
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hdr_ok     <= 1'b0;
			cmd_valid  <= 1'b0;
			cmd_code   <= sfcd_pkg::CMD_NONE;
			cmd_page   <= '0;
			cmd_byte   <= '0;
			reject     <= 1'b0;
			data_valid <= 1'b0;
			data_byte  <= 8'h00;
			launch     <= 1'b0;
			launch_cmd <= sfcd_pkg::CMD_NONE;
		end else begin
			hdr_ok     <= !cs_n && (hdr_ok || fire);
			cmd_valid  <= fire;
			reject     <= bad;
			data_valid <= pass;
			launch     <= cs_n && hdr_ok && launchable; // see R11 see R12 see R14
			if (fire) begin
				cmd_code <= next_cmd;
				cmd_page <= page_sel;
				cmd_byte <= byte_sel;
			end
			if (pass) data_byte <= rx_byte;
			if (cs_n && hdr_ok) launch_cmd <= cmd;
		end
	end

	assign stream_on = (state == ST_DATA) && !cs_n;

	// ==========================================================
	// Checks
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) nbytes <= 4'h0;
		else if (cs_n) nbytes <= 4'h0;
		else if (take && nbytes != 4'hF) nbytes <= nbytes + 4'h1;
	end

	property p_page_rd_hdr;
		@(posedge clk) disable iff (!arst_n)
		cmd_valid && cmd_code == sfcd_pkg::CMD_PG_RD |-> nbytes == 4'h8;
	endproperty
	a_page_rd_hdr: assert property (p_page_rd_hdr) else $error("page read header length"); // see R06

	property p_ar_lf_hdr;
		@(posedge clk) disable iff (!arst_n)
		cmd_valid && cmd_code == sfcd_pkg::CMD_AR_LF |-> nbytes == 4'h4;
	endproperty
	a_ar_lf_hdr: assert property (p_ar_lf_hdr) else $error("slow array read header"); // see R07

	property p_ar_hf_hdr;
		@(posedge clk) disable iff (!arst_n)
		cmd_valid && cmd_code == sfcd_pkg::CMD_AR_HF |-> nbytes == 4'h5 && stream_on == !cs_n;
	endproperty
	a_ar_hf_hdr: assert property (p_ar_hf_hdr) else $error("fast array read header"); // see R08

	property p_ar_old_hdr;
		@(posedge clk) disable iff (!arst_n)
		cmd_valid && cmd_code == sfcd_pkg::CMD_AR_OLD |-> nbytes == 4'h8;
	endproperty
	a_ar_old_hdr: assert property (p_ar_old_hdr) else $error("old array read header"); // see R09

	property p_buf_rd_hdr;
		@(posedge clk) disable iff (!arst_n)
		cmd_valid && cmd_code inside {sfcd_pkg::CMD_BR, sfcd_pkg::CMD_BR_LF} |->
			nbytes == ((cmd_code == sfcd_pkg::CMD_BR) ? 4'h5 : 4'h4);
	endproperty
	a_buf_rd_hdr: assert property (p_buf_rd_hdr) else $error("buffer read header"); // see R10

	property p_short_hdr;
		@(posedge clk) disable iff (!arst_n)
		cmd_valid && cmd_code inside {sfcd_pkg::CMD_STAT, sfcd_pkg::CMD_ID} |-> nbytes == 4'h1;
	endproperty
	a_short_hdr: assert property (p_short_hdr) else $error("status or id header"); // see R21

	property p_bin_byte;
		@(posedge clk) disable iff (!arst_n)
		fire && page_256 |=> cmd_byte[PAGE_W-1] == 1'b0 && cmd_valid;
	endproperty
	a_bin_byte: assert property (p_bin_byte) else $error("binary byte address too wide"); // see R24

	property p_reject;
		@(posedge clk) disable iff (!arst_n)
		take && state == ST_OPC && !dif.allowed |=> reject ##1 !stream_on;
	endproperty
	a_reject: assert property (p_reject) else $error("disallowed opcode not refused"); // see R03
endmodule

// ### src/sfcd_dec_if.sv
// Decoder, guard and core signals that travel together
interface sfcd_dec_if;
	logic [7:0]          opcode;
	sfcd_pkg::sfcd_cmd_t cmd;
	sfcd_pkg::sfcd_grp_t grp;
	logic                has_addr;
	logic [2:0]          n_dummy;
	logic                allowed;

	modport core  (output opcode, input cmd, grp, has_addr, n_dummy, allowed);
	modport dec   (input opcode, output cmd, grp, has_addr, n_dummy);
	modport guard (input cmd, grp, output allowed);
endinterface

// ### src/sfcd_guard.sv
// Self-timed operation tracker and command admission
module sfcd_guard (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	// Launch and completion
	input  wire logic                 launch,
	input  wire sfcd_pkg::sfcd_cmd_t  launch_cmd,
	input  wire logic                 op_done,
	// Decoder view
	sfcd_dec_if.guard                 dif,
	// State
	output sfcd_pkg::sfcd_busy_t      busy,
	output logic                      pd
);
	sfcd_pkg::sfcd_grp_t  lgrp;
	sfcd_pkg::sfcd_busy_t st_class;
	sfcd_pkg::sfcd_busy_t next_busy;
	logic                 next_pd;
	logic                 is_buf;
	logic                 is_st;
	logic                 is_id;
	logic                 allowed_busy;

	// ==========================================================
	// Busy class; a launch that has a busy class wins over a completion in the same cycle
	assign lgrp = sfcd_pkg::sfcd_grp(launch_cmd);
	assign st_class = (lgrp == sfcd_pkg::GRP_B_ER) ? sfcd_pkg::BUSY_ERASE :
		(lgrp == sfcd_pkg::GRP_B_XF) ? sfcd_pkg::BUSY_XFER :
		(lgrp == sfcd_pkg::GRP_D) ? sfcd_pkg::BUSY_NVCFG : sfcd_pkg::BUSY_NONE; // see R05
	assign next_busy = (launch && st_class != sfcd_pkg::BUSY_NONE) ? st_class :
		op_done ? sfcd_pkg::BUSY_NONE : busy;
	assign next_pd = (launch && launch_cmd == sfcd_pkg::CMD_DPD) ? 1'b1 :
		(launch && launch_cmd == sfcd_pkg::CMD_RESUME) ? 1'b0 : pd; // see R20

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy <= sfcd_pkg::BUSY_NONE;
			pd   <= 1'b0;
		end else begin
			busy <= next_busy;
			pd   <= next_pd;
		end
	end

	// ==========================================================
	// Admission
	assign is_buf = dif.grp == sfcd_pkg::GRP_C_BUF;
	assign is_st  = dif.grp == sfcd_pkg::GRP_C_ST;
	assign is_id  = dif.grp == sfcd_pkg::GRP_C_ID;
	assign allowed_busy = (busy == sfcd_pkg::BUSY_NONE) ? (dif.grp != sfcd_pkg::GRP_BAD) :
		(busy == sfcd_pkg::BUSY_ERASE) ? (is_buf || is_st || is_id) : // see R02
		(busy == sfcd_pkg::BUSY_XFER) ? (is_st || is_id) : // see R03
		is_st; // see R04 see R05
	// Powered down, only the resume opcode is heard
	assign dif.allowed = pd ? (dif.cmd == sfcd_pkg::CMD_RESUME) : allowed_busy; // see R20

	// ==========================================================
	// Checks
	property p_erase_admit;
		@(posedge clk) disable iff (!arst_n)
		busy == sfcd_pkg::BUSY_ERASE && !pd |-> dif.allowed == (is_buf || is_st || is_id);
	endproperty
	a_erase_admit: assert property (p_erase_admit) else $error("erase admission wrong"); // see R02

	property p_xfer_admit;
		@(posedge clk) disable iff (!arst_n)
		busy == sfcd_pkg::BUSY_XFER && !pd |-> dif.allowed == (is_st || is_id);
	endproperty
	a_xfer_admit: assert property (p_xfer_admit) else $error("transfer admission wrong"); // see R03

	property p_nvcfg_launch;
		@(posedge clk) disable iff (!arst_n)
		launch && lgrp == sfcd_pkg::GRP_D |=> busy == sfcd_pkg::BUSY_NVCFG && (dif.allowed ==
			(pd ? dif.cmd == sfcd_pkg::CMD_RESUME : is_st));
	endproperty
	a_nvcfg_launch: assert property (p_nvcfg_launch) else $error("nv config class wrong"); // see R05

	property p_pd_entry;
		@(posedge clk) disable iff (!arst_n)
		launch && launch_cmd == sfcd_pkg::CMD_DPD |=> pd ##0 (dif.allowed ==
			(dif.cmd == sfcd_pkg::CMD_RESUME));
	endproperty
	a_pd_entry: assert property (p_pd_entry) else $error("power down not entered"); // see R20
endmodule

// ### src/sfcd_opdec.sv
// First-byte opcode decoder
module sfcd_opdec (
	// Decoder view
	sfcd_dec_if.dec dif
);
	sfcd_pkg::sfcd_cmd_t c;

	// ==========================================================
	// Opcode table
	always_comb begin
		case (dif.opcode)
			sfcd_pkg::OP_PG_RD, sfcd_pkg::OP_L_PG_RD: c = sfcd_pkg::CMD_PG_RD; // see R06 see R22
			sfcd_pkg::OP_AR_LF:   c = sfcd_pkg::CMD_AR_LF; // see R07
			sfcd_pkg::OP_AR_HF:   c = sfcd_pkg::CMD_AR_HF; // see R08
			sfcd_pkg::OP_AR_OLD, sfcd_pkg::OP_L_AR: c = sfcd_pkg::CMD_AR_OLD; // see R09 see R22
			sfcd_pkg::OP_BR_LF:   c = sfcd_pkg::CMD_BR_LF; // see R10
			sfcd_pkg::OP_BR, sfcd_pkg::OP_L_BR: c = sfcd_pkg::CMD_BR; // see R10 see R22
			sfcd_pkg::OP_BW:      c = sfcd_pkg::CMD_BW; // see R23
			sfcd_pkg::OP_PGM_ER:  c = sfcd_pkg::CMD_PGM_ER; // see R11
			sfcd_pkg::OP_PGM_NE:  c = sfcd_pkg::CMD_PGM_NE; // see R12
			sfcd_pkg::OP_PGM_TB:  c = sfcd_pkg::CMD_PGM_TB; // see R13
			sfcd_pkg::OP_ER_PG:   c = sfcd_pkg::CMD_ER_PG; // see R23
			sfcd_pkg::OP_ER_BLK:  c = sfcd_pkg::CMD_ER_BLK; // see R23
			sfcd_pkg::OP_ER_SEC:  c = sfcd_pkg::CMD_ER_SEC; // see R23
			sfcd_pkg::OP_XFER:    c = sfcd_pkg::CMD_XFER; // see R14
			sfcd_pkg::OP_CMP:     c = sfcd_pkg::CMD_CMP; // see R14
			sfcd_pkg::OP_REWR:    c = sfcd_pkg::CMD_REWR; // see R14
			sfcd_pkg::OP_PFX:     c = sfcd_pkg::CMD_PFX; // see R15
			sfcd_pkg::OP_SEC_PGM: c = sfcd_pkg::CMD_SEC_PGM; // see R18
			sfcd_pkg::OP_PREG_RD: c = sfcd_pkg::CMD_PREG_RD; // see R19
			sfcd_pkg::OP_LOCK_RD: c = sfcd_pkg::CMD_LOCK_RD; // see R19
			sfcd_pkg::OP_SEC_RD:  c = sfcd_pkg::CMD_SEC_RD; // see R19
			sfcd_pkg::OP_DPD:     c = sfcd_pkg::CMD_DPD; // see R20
			sfcd_pkg::OP_RESUME:  c = sfcd_pkg::CMD_RESUME; // see R20
			sfcd_pkg::OP_STAT, sfcd_pkg::OP_L_STAT: c = sfcd_pkg::CMD_STAT; // see R21 see R22
			sfcd_pkg::OP_ID:      c = sfcd_pkg::CMD_ID; // see R21
			default:              c = sfcd_pkg::CMD_NONE;
		endcase
	end

	// ==========================================================
	// Header shape
	assign dif.cmd = c;
	assign dif.grp = sfcd_pkg::sfcd_grp(c);
	// Three address bytes for all but the short commands
	assign dif.has_addr = !(c inside {sfcd_pkg::CMD_NONE, sfcd_pkg::CMD_STAT, sfcd_pkg::CMD_ID,
		sfcd_pkg::CMD_DPD, sfcd_pkg::CMD_RESUME}); // see R20 see R21
	assign dif.n_dummy = (c inside {sfcd_pkg::CMD_PG_RD, sfcd_pkg::CMD_AR_OLD}) ?
		sfcd_pkg::DUMMY_FOUR : // see R06 see R09
		(c inside {sfcd_pkg::CMD_AR_HF, sfcd_pkg::CMD_BR}) ? sfcd_pkg::DUMMY_ONE : // see R08 see R10
		3'h0;
endmodule

// ### src/sfcd_pkg.sv
// Shared opcodes, command codes, groups and field positions of the command decoder
package sfcd_pkg;

	// ==========================================================
	// Opcodes
	localparam logic [7:0] OP_PG_RD   = 8'hD2;
	localparam logic [7:0] OP_AR_LF   = 8'h03;
	localparam logic [7:0] OP_AR_HF   = 8'h0B;
	localparam logic [7:0] OP_AR_OLD  = 8'hE8;
	localparam logic [7:0] OP_BR_LF   = 8'hD1;
	localparam logic [7:0] OP_BR      = 8'hD4;
	localparam logic [7:0] OP_BW      = 8'h84;
	localparam logic [7:0] OP_PGM_ER  = 8'h83;
	localparam logic [7:0] OP_PGM_NE  = 8'h88;
	localparam logic [7:0] OP_PGM_TB  = 8'h82;
	localparam logic [7:0] OP_ER_PG   = 8'h81;
	localparam logic [7:0] OP_ER_BLK  = 8'h50;
	localparam logic [7:0] OP_ER_SEC  = 8'h7C;
	localparam logic [7:0] OP_XFER    = 8'h53;
	localparam logic [7:0] OP_CMP     = 8'h60;
	localparam logic [7:0] OP_REWR    = 8'h58;
	localparam logic [7:0] OP_PFX     = 8'h3D;
	localparam logic [7:0] OP_SEC_PGM = 8'h9B;
	localparam logic [7:0] OP_PREG_RD = 8'h32;
	localparam logic [7:0] OP_LOCK_RD = 8'h35;
	localparam logic [7:0] OP_SEC_RD  = 8'h77;
	localparam logic [7:0] OP_DPD     = 8'hB9;
	localparam logic [7:0] OP_RESUME  = 8'hAB;
	localparam logic [7:0] OP_STAT    = 8'hD7;
	localparam logic [7:0] OP_ID      = 8'h9F;
	localparam logic [7:0] OP_L_BR    = 8'h54;
	localparam logic [7:0] OP_L_PG_RD = 8'h52;
	localparam logic [7:0] OP_L_AR    = 8'h68;
	localparam logic [7:0] OP_L_STAT  = 8'h57;

	// ==========================================================
	// Multi-byte sequence tails
	localparam logic [15:0] PFX_TAIL  = 16'h2A7F;
	localparam logic [7:0]  SEL_EN    = 8'hA9;
	localparam logic [7:0]  SEL_DIS   = 8'h9A;
	localparam logic [7:0]  SEL_PR_ER = 8'hCF;
	localparam logic [7:0]  SEL_PR_PG = 8'hFC;
	localparam logic [7:0]  SEL_LOCK  = 8'h30;
	localparam logic [23:0] CHIP_TAIL = 24'h94_809A;
	localparam logic [23:0] SEC_TAIL  = 24'h00_0000;

	// ==========================================================
	// Header lengths and address layout
	localparam logic [2:0] ADDR_LAST  = 3'h2;
	localparam logic [2:0] DUMMY_ONE  = 3'h1;
	localparam logic [2:0] DUMMY_FOUR = 3'h4;
	localparam int         PAGE_BITS  = 9;
	localparam int         A256_PG_LSB = 8;
	localparam int         A264_PG_LSB = 9;

	// ==========================================================
	// Types
	typedef enum logic [4:0] {
		CMD_NONE, CMD_PG_RD, CMD_AR_LF, CMD_AR_HF, CMD_AR_OLD, CMD_BR_LF, CMD_BR, CMD_BW,
		CMD_PGM_ER, CMD_PGM_NE, CMD_PGM_TB, CMD_ER_PG, CMD_ER_BLK, CMD_ER_SEC, CMD_ER_CHIP,
		CMD_XFER, CMD_CMP, CMD_REWR, CMD_PFX, CMD_PROT_EN, CMD_PROT_DIS, CMD_PREG_ER,
		CMD_PREG_PGM, CMD_LOCK, CMD_SEC_PGM, CMD_PREG_RD, CMD_LOCK_RD, CMD_SEC_RD,
		CMD_DPD, CMD_RESUME, CMD_STAT, CMD_ID
	} sfcd_cmd_t;

	typedef enum logic [3:0] {
		GRP_A, GRP_B_ER, GRP_B_XF, GRP_C_BUF, GRP_C_ST, GRP_C_ID, GRP_D, GRP_MISC,
		GRP_PWR, GRP_BAD
	} sfcd_grp_t;

	typedef enum logic [1:0] {
		BUSY_NONE  = 2'b00,
		BUSY_ERASE = 2'b01,
		BUSY_XFER  = 2'b10,
		BUSY_NVCFG = 2'b11
	} sfcd_busy_t;

	// Concurrency class of a command
	function automatic sfcd_grp_t sfcd_grp(input sfcd_cmd_t c);
		case (c)
			CMD_PG_RD, CMD_AR_LF, CMD_AR_HF, CMD_AR_OLD,
			CMD_PREG_RD, CMD_LOCK_RD, CMD_SEC_RD:          sfcd_grp = GRP_A;
			CMD_ER_PG, CMD_ER_BLK, CMD_ER_SEC, CMD_ER_CHIP: sfcd_grp = GRP_B_ER;
			CMD_XFER, CMD_CMP, CMD_PGM_ER, CMD_PGM_NE,
			CMD_PGM_TB, CMD_REWR:                          sfcd_grp = GRP_B_XF;
			CMD_BR_LF, CMD_BR, CMD_BW:                     sfcd_grp = GRP_C_BUF;
			CMD_STAT:                                      sfcd_grp = GRP_C_ST;
			CMD_ID:                                        sfcd_grp = GRP_C_ID;
			CMD_PREG_ER, CMD_PREG_PGM, CMD_LOCK,
			CMD_SEC_PGM:                                   sfcd_grp = GRP_D;
			CMD_PFX, CMD_PROT_EN, CMD_PROT_DIS:            sfcd_grp = GRP_MISC;
			CMD_DPD, CMD_RESUME:                           sfcd_grp = GRP_PWR;
			default:                                       sfcd_grp = GRP_BAD;
		endcase
	endfunction

endpackage
